// ---- scea_pkg.sv ----
// Shared constants and types for the stack check and address generation block
package scea_pkg;
  localparam int          DATA_W        = 16;
  localparam int          NREGS         = 16;
  localparam int          FILE_ADDR_W   = 13;
  localparam int          LIT_W         = 10;
  localparam logic [3:0]  SP_INDEX      = 4'hf;
  localparam logic [3:0]  DEFAULT_WORKING_REG_INDEX    = 4'h0;
  localparam logic [15:0] STACK_FLOOR   = 16'h0800;
  localparam logic [15:0] WORD_STEP     = 16'h0002;
  localparam logic [15:0] DEFAULT_WORKING_REG_RESET    = 16'h0000;
  localparam logic [15:0] SP_RESET      = 16'h0800;
  localparam int          SRL_POS       = 8;
  localparam logic [15:0] BOOT_RAM_LO   = 16'h0800;
  localparam logic [15:0] BOOT_RAM_HI   = 16'h08ff;
  localparam logic [15:0] SEG_RAM_LO    = 16'h0900;
  localparam logic [15:0] SEG_RAM_HI    = 16'h09ff;

  typedef enum logic [3:0] {
    SCEA_FILE_DIRECT,
    SCEA_REG_DIRECT,
    SCEA_IND,
    SCEA_IND_POST,
    SCEA_IND_PRE,
    SCEA_IND_REG_OFS,
    SCEA_IND_LIT_OFS,
    SCEA_LITERAL,
    SCEA_PUSH,
    SCEA_POP,
    SCEA_CALL_PUSH,
    SCEA_EXC_PUSH,
    SCEA_LIMIT_WRITE,
    SCEA_REG_WRITE
  } scea_op_e;

  typedef enum logic [1:0] {
    SCEA_CODE_OTHER,
    SCEA_CODE_BOOT,
    SCEA_CODE_SECURE
  } scea_code_e;
endpackage

// ---- scea_ram_guard.sv ----
// Secure RAM segment access guard
`timescale 1ns/1ps
`default_nettype none
module scea_ram_guard
(
  input  wire logic [15:0]         addr,
  input  wire logic                access,
  input  wire scea_pkg::scea_code_e codeSeg,
  input  wire logic                bootRamEn,
  input  wire logic                segRamEn,
  output logic                     denied
);
  logic inBoot;
  logic inSeg;
  always_comb
  begin
    inBoot = (addr >= scea_pkg::BOOT_RAM_LO) && (addr <= scea_pkg::BOOT_RAM_HI);
    inSeg  = (addr >= scea_pkg::SEG_RAM_LO) && (addr <= scea_pkg::SEG_RAM_HI);
    denied = access && ((bootRamEn && inBoot && codeSeg != scea_pkg::SCEA_CODE_BOOT)
           || (segRamEn && inSeg && codeSeg != scea_pkg::SCEA_CODE_SECURE));
  end
endmodule // scea_ram_guard
`default_nettype wire

// ---- scea_core.sv ----
// Address generation, working registers and stack checking
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Stack pointer holds next free word, grows up
// - Pop pre-decrements, push post-increments
// - Call push clears upper counter bits
// - Exception push adds status low byte
// - Stack limit not set by reset
// - Stack limit bit 0 reads zero
// - Stack pointer write addresses checked against limit
// - Push at limit passes, next traps
// - Stack address below floor traps
// - Boot secure RAM only from boot code
// - Segment secure RAM only from secure code
// - File address is 13 bits, near space
// - Register zero is default working register
// - Move reaches whole data space
// - First operand always register direct base
// - Direct, indirect, post, pre, literal modes
// - Post-modify uses pointer then updates
// - Pre-modify updates pointer then uses
// - Register offset adds pointer and base
// - Literal offset adds pointer and literal
// - File direct address from instruction
module scea_core
#(
  parameter int DATA_W = scea_pkg::DATA_W
)
(
  input  wire logic                 ref_clk,
  input  wire logic                 arst_n,
  input  wire logic                 opValid,
  input  wire scea_pkg::scea_op_e   opMode,
  input  wire logic                 opWrite,
  input  wire logic                 opMove,
  input  wire logic                 opToWreg,
  input  wire logic [3:0]           pointerSel,
  input  wire logic [3:0]           baseSel,
  input  wire logic [12:0]          fileAddr,
  input  wire logic [15:0]          moveAddr,
  input  wire logic [9:0]           literal,
  input  wire logic                 literalWide,
  input  wire logic signed [15:0]   modAmount,
  input  wire logic [15:0]          wrData,
  input  wire logic [22:0]          pcValue,
  input  wire logic [7:0]           status_low_byte,
  input  wire scea_pkg::scea_code_e codeSeg,
  input  wire logic                 bootRamEn,
  input  wire logic                 segRamEn,
  output logic [15:0]               memAddr,
  output logic [15:0]               memWdata,
  output logic                      memWe,
  output logic                      memRe,
  output logic [15:0]               operand1,
  output logic [15:0]               operand2,
  output logic [15:0]               stackPtr,
  output logic [15:0]               stackLimit,
  output logic                      stackTrap,
  output logic                      accessViolation
);
  logic [15:0] regs_reg [scea_pkg::NREGS];
  logic [15:0] regs_next [scea_pkg::NREGS];
  logic [15:0] stack_limit_reg;
  logic [15:0] stack_limit_next;
  logic [15:0] memAddr_reg, memAddr_next, memWdata_reg, memWdata_next;
  logic [15:0] op1_reg, op1_next, op2_reg, op2_next;
  logic        memWe_reg, memWe_next, memRe_reg, memRe_next;
  logic        trap_reg, trap_next, viol_reg, viol_next;
  logic [15:0] ea;
  logic [15:0] ptrVal;
  logic        access, isWrite, usesSp, denied;

  function automatic logic [15:0] lit_ext(input logic [9:0] l, input logic wide);
    lit_ext = wide ? {6'h00, l} : {11'h000, l[4:0]};
  endfunction

  function automatic logic stack_bad(input logic [15:0] a, input logic [15:0] lim,
                                     input logic push);
    stack_bad = (a < scea_pkg::STACK_FLOOR) || (push ? (a > lim) : 1'b0);
  endfunction

  scea_ram_guard u_guard
  (
    .addr      (ea),
    .access    (access),
    .codeSeg   (codeSeg),
    .bootRamEn (bootRamEn),
    .segRamEn  (segRamEn),
    .denied    (denied)
  );

  always_comb
  begin
    regs_next        = regs_reg;
    stack_limit_next = stack_limit_reg;
    ptrVal           = regs_reg[pointerSel];
    ea               = 16'h0000;
    access           = 1'b0;
    isWrite          = 1'b0;
    usesSp           = 1'b0;
    memWdata_next    = wrData;
    op1_next         = regs_reg[baseSel];
    op2_next         = op2_reg;
    if (opValid)
    begin
      unique case (opMode)
        scea_pkg::SCEA_FILE_DIRECT:
        begin
          ea      = opMove ? moveAddr : {3'h0, fileAddr};
          access  = 1'b1;
          isWrite = opWrite && !opToWreg;
        end
        scea_pkg::SCEA_REG_DIRECT:
          op2_next = ptrVal;
        scea_pkg::SCEA_IND:
        begin
          ea      = ptrVal;
          access  = 1'b1;
          isWrite = opWrite;
          usesSp  = pointerSel == scea_pkg::SP_INDEX;
        end
        scea_pkg::SCEA_IND_POST:
        begin
          ea      = ptrVal;
          access  = 1'b1;
          isWrite = opWrite;
          usesSp  = pointerSel == scea_pkg::SP_INDEX;
          regs_next[pointerSel] = ptrVal + modAmount;
        end
        scea_pkg::SCEA_IND_PRE:
        begin
          ea      = ptrVal + modAmount;
          access  = 1'b1;
          isWrite = opWrite;
          usesSp  = pointerSel == scea_pkg::SP_INDEX;
          regs_next[pointerSel] = ea;
        end
        scea_pkg::SCEA_IND_REG_OFS:
        begin
          ea      = ptrVal + regs_reg[baseSel];
          access  = 1'b1;
          isWrite = opWrite;
          usesSp  = pointerSel == scea_pkg::SP_INDEX;
        end
        scea_pkg::SCEA_IND_LIT_OFS:
        begin
          ea      = ptrVal + lit_ext(literal, literalWide);
          access  = 1'b1;
          isWrite = opWrite;
          usesSp  = pointerSel == scea_pkg::SP_INDEX;
        end
        scea_pkg::SCEA_LITERAL:
          op2_next = lit_ext(literal, literalWide);
        scea_pkg::SCEA_PUSH, scea_pkg::SCEA_CALL_PUSH, scea_pkg::SCEA_EXC_PUSH:
        begin
          ea      = regs_reg[scea_pkg::SP_INDEX];
          access  = 1'b1;
          isWrite = 1'b1;
          usesSp  = 1'b1;
          regs_next[scea_pkg::SP_INDEX] = ea + scea_pkg::WORD_STEP;
          if (opMode == scea_pkg::SCEA_CALL_PUSH)
            memWdata_next = {9'h000, pcValue[22:16]};
          else if (opMode == scea_pkg::SCEA_EXC_PUSH)
            memWdata_next = {status_low_byte, 1'b0, pcValue[22:16]};
        end
        scea_pkg::SCEA_POP:
        begin
          ea      = regs_reg[scea_pkg::SP_INDEX] - scea_pkg::WORD_STEP;
          access  = 1'b1;
          usesSp  = 1'b1;
          regs_next[scea_pkg::SP_INDEX] = ea;
        end
        scea_pkg::SCEA_LIMIT_WRITE:
          stack_limit_next = {wrData[15:1], 1'b0};
        scea_pkg::SCEA_REG_WRITE:
          regs_next[opToWreg ? scea_pkg::DEFAULT_WORKING_REG_INDEX : baseSel] = wrData;
        default:
          ea = 16'h0000;
      endcase
    end
    // A pointer already under the floor traps even if the address wraps
    trap_next = access && usesSp
              && (stack_bad(ea, stack_limit_reg, isWrite)
                  || regs_reg[scea_pkg::SP_INDEX] < scea_pkg::STACK_FLOOR);
    viol_next    = denied;
    memWe_next   = isWrite && !denied && !trap_next;
    memRe_next   = access && !isWrite && !denied;
    memAddr_next = ea;
    if (opValid && opMode == scea_pkg::SCEA_FILE_DIRECT && opToWreg && opWrite)
      regs_next[scea_pkg::DEFAULT_WORKING_REG_INDEX] = wrData;
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < scea_pkg::NREGS; i++)
        regs_reg[i] <= scea_pkg::DEFAULT_WORKING_REG_RESET;
      regs_reg[scea_pkg::SP_INDEX] <= scea_pkg::SP_RESET;
      memAddr_reg  <= 16'h0000;
      memWdata_reg <= 16'h0000;
      op1_reg      <= 16'h0000;
      op2_reg      <= 16'h0000;
      memWe_reg    <= 1'b0;
      memRe_reg    <= 1'b0;
      trap_reg     <= 1'b0;
      viol_reg     <= 1'b0;
    end
    else
    begin
      regs_reg     <= regs_next;
      memAddr_reg  <= memAddr_next;
      memWdata_reg <= memWdata_next;
      op1_reg      <= op1_next;
      op2_reg      <= op2_next;
      memWe_reg    <= memWe_next;
      memRe_reg    <= memRe_next;
      trap_reg     <= trap_next;
      viol_reg     <= viol_next;
    end
  end

  // Limit has no reset term
  always_ff @(posedge ref_clk)
  begin
    stack_limit_reg <= stack_limit_next;
  end

  assign memAddr         = memAddr_reg;
  assign memWdata        = memWdata_reg;
  assign memWe           = memWe_reg;
  assign memRe           = memRe_reg;
  assign operand1        = op1_reg;
  assign operand2        = op2_reg;
  assign stackPtr        = regs_reg[scea_pkg::SP_INDEX];
  assign stackLimit      = stack_limit_reg;
  assign stackTrap       = trap_reg;
  assign accessViolation = viol_reg;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  AST_PUSH_INC: assert property (opValid && opMode == scea_pkg::SCEA_PUSH
    |=> stackPtr == $past(stackPtr) + 16'h0002) else $error("push did not add two");
  AST_POP_DEC: assert property (opValid && opMode == scea_pkg::SCEA_POP
    |=> memAddr == $past(stackPtr) - 16'h0002) else $error("pop address wrong");
  AST_LIMIT_EVEN: assert property (opValid && opMode == scea_pkg::SCEA_LIMIT_WRITE
    |=> stackLimit == {$past(wrData[15:1]), 1'b0}) else $error("limit bit zero set");
  AST_FLOOR_TRAP: assert property (opValid && opMode == scea_pkg::SCEA_POP
    && stackPtr < 16'h0802 |=> stackTrap) else $error("floor trap missing");
  AST_AT_LIMIT_OK: assert property (opValid && opMode == scea_pkg::SCEA_PUSH
    && stackPtr == stackLimit && stackPtr >= 16'h0800 |=> !stackTrap)
    else $error("trap at limit");
  AST_OVER_LIMIT: assert property (opValid && opMode == scea_pkg::SCEA_PUSH
    && stackPtr > stackLimit |=> stackTrap) else $error("overflow trap missing");
  AST_TRAP_PULSE: assert property (stackTrap |-> $past(opValid) && $past(usesSp))
    else $error("trap without stack access");
  AST_CALL_MSB: assert property (opValid && opMode == scea_pkg::SCEA_CALL_PUSH
    |=> memWdata[15:7] == 9'h000) else $error("call push upper bits set");
  AST_DENY_NOWR: assert property (accessViolation |-> !memWe)
    else $error("denied access wrote memory");
  AST_POST_ADDR: assert property (opValid && opMode == scea_pkg::SCEA_IND_POST
    |=> memAddr == $past(regs_reg[pointerSel])) else $error("post-modify address wrong");
  // Addressing mode, data and idle checks
  AST_POST_WB: assert property (opValid && opMode == scea_pkg::SCEA_IND_POST
    |=> regs_reg[$past(pointerSel)] == 16'(memAddr + $past(modAmount)))
    else $error("post-modify update wrong");
  AST_PRE_ADDR: assert property (opValid && opMode == scea_pkg::SCEA_IND_PRE
    |=> memAddr == 16'($past(regs_reg[pointerSel]) + $past(modAmount)))
    else $error("pre-modify address wrong");
  AST_PRE_WB: assert property (opValid && opMode == scea_pkg::SCEA_IND_PRE
    |=> regs_reg[$past(pointerSel)] == memAddr) else $error("pre-modify update wrong");
  AST_REG_OFS: assert property (opValid && opMode == scea_pkg::SCEA_IND_REG_OFS
    |=> memAddr == 16'($past(regs_reg[pointerSel]) + $past(regs_reg[baseSel])))
    else $error("register offset address wrong");
  AST_FILE_ADDR: assert property (opValid && opMode == scea_pkg::SCEA_FILE_DIRECT && !opMove
    |=> memAddr == {3'h0, $past(fileAddr)}) else $error("file address wrong");
  AST_MOVE_ADDR: assert property (opValid && opMode == scea_pkg::SCEA_FILE_DIRECT && opMove
    |=> memAddr == $past(moveAddr)) else $error("move address wrong");
  AST_EXC_DATA: assert property (opValid && opMode == scea_pkg::SCEA_EXC_PUSH
    |=> memWdata == {$past(status_low_byte), 1'b0, $past(pcValue[22:16])})
    else $error("exception push data wrong");
  AST_TRAP_NOWR: assert property (stackTrap |-> !memWe)
    else $error("trapped access wrote memory");
  AST_IDLE_QUIET: assert property (!opValid
    |=> !memWe && !memRe && !stackTrap && !accessViolation)
    else $error("strobe without an op");
  AST_OP1_BASE: assert property (opValid |=> operand1 == $past(regs_reg[baseSel]))
    else $error("first operand wrong");
  AST_DEFAULT_WORKING_REG: assert property (opValid && opMode == scea_pkg::SCEA_FILE_DIRECT
    && opToWreg && opWrite |=> regs_reg[scea_pkg::DEFAULT_WORKING_REG_INDEX] == $past(wrData) && !memWe)
    else $error("default register result wrong");

  CV_PUSH: cover property (opValid && opMode == scea_pkg::SCEA_PUSH ##1 !stackTrap);
  CV_TRAP: cover property (stackTrap);
  CV_VIOL: cover property (accessViolation);
  CV_FLOOR: cover property (opValid && opMode == scea_pkg::SCEA_POP ##1 stackTrap);
  CV_EXC: cover property (opValid && opMode == scea_pkg::SCEA_EXC_PUSH);
endmodule // scea_core
`default_nettype wire

// ---- scea_mem_model.sv ----
// Data memory model on the far side of the core's memory port
`timescale 1ns/1ps
`default_nettype none
module scea_mem_model
(
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  input  wire logic [15:0] memAddr,
  input  wire logic [15:0] memWdata,
  input  wire logic        memWe,
  output logic [15:0]      wrCount,
  output logic [15:0]      lastAddr,
  output logic [15:0]      lastData
);
  // Only a granted write pulse changes what the memory holds
  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wrCount  <= 16'h0000;
      lastAddr <= 16'h0000;
      lastData <= 16'h0000;
    end
    else if (memWe)
    begin
      lastAddr <= memAddr;
      lastData <= memWdata;
      wrCount  <= wrCount + 16'h0001;
    end
  end
endmodule // scea_mem_model
`default_nettype wire

// ---- stack_check_and_ea_generation_bench.sv ----
// Self-checking bench for the stack check and address generation core
`timescale 1ns/1ps
`default_nettype none
module stack_check_and_ea_generation_bench;
  logic                 ref_clk = 1'b0;
  logic                 arst_n = 1'b0;
  logic                 opValid = 1'b0;
  logic                 opWrite = 1'b0;
  logic                 opMove = 1'b0;
  logic                 opToWreg = 1'b0;
  logic                 literalWide = 1'b0;
  logic                 bootRamEn = 1'b0;
  logic                 segRamEn = 1'b0;
  scea_pkg::scea_op_e   opMode = scea_pkg::SCEA_REG_DIRECT;
  scea_pkg::scea_code_e codeSeg = scea_pkg::SCEA_CODE_OTHER;
  logic [3:0]           pointerSel = 4'h0;
  logic [3:0]           baseSel = 4'h4;
  logic [12:0]          fileAddr = 13'h1abc;
  logic [15:0]          moveAddr = 16'hfedc;
  logic [15:0]          wrData = 16'h0000;
  logic signed [15:0]   modAmount = 16'sh0000;
  logic [9:0]           literal = 10'h3ec;
  logic [22:0]          pcValue = 23'h7abcde;
  logic [7:0]           lowStatus = 8'ha5;
  wire logic [15:0]     memAddr, memWdata, operand1, operand2;
  wire logic [15:0]     stackPtr, stackLimit, wrCount, lastAddr, lastData;
  wire logic            memWe, memRe, stackTrap, accessViolation;
  int                   err_count = 0;
  int                   n_compared = 0;
  int                   cycles = 0;
  logic [15:0]          seen;

  scea_core uut
  (
    .ref_clk, .arst_n, .opValid, .opMode, .opWrite, .opMove, .opToWreg, .pointerSel,
    .baseSel, .fileAddr, .moveAddr, .literal, .literalWide, .modAmount, .wrData,
    .pcValue, .status_low_byte(lowStatus), .codeSeg, .bootRamEn, .segRamEn, .memAddr,
    .memWdata, .memWe, .memRe, .operand1, .operand2, .stackPtr, .stackLimit,
    .stackTrap, .accessViolation
  );

  scea_mem_model mem
  (
    .ref_clk, .arst_n, .memAddr, .memWdata, .memWe, .wrCount, .lastAddr, .lastData
  );

  always #5 ref_clk = ~ref_clk;

  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      err_count++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic do_reset();
    @(posedge ref_clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    #1;
  endtask

  // One op driven after an edge and taken at the next; results are settled just after that edge
  task automatic op(input scea_pkg::scea_op_e m, input logic [3:0] p,
                    input logic signed [15:0] md, input logic [15:0] d, input logic w);
    @(posedge ref_clk);
    opValid <= 1'b1;
    opMode <= m;
    pointerSel <= p;
    // A register write lands in the register that baseSel names
    baseSel <= (m == scea_pkg::SCEA_REG_WRITE) ? p : 4'h4;
    modAmount <= md;
    wrData <= d;
    opWrite <= w;
    @(posedge ref_clk);
    opValid <= 1'b0;
    #1;
  endtask

  task automatic t_stack();
    chk("sp reset", 16'h0800, stackPtr);
    // Limit is unknown after power-up, so set it clear of the pushes
    op(scea_pkg::SCEA_LIMIT_WRITE, 4'h0, 16'sh0000, 16'hfffe, 1'b0);
    op(scea_pkg::SCEA_PUSH, 4'h0, 16'sh0000, 16'h1234, 1'b1);
    chk("push we", 16'h0001, 16'(memWe));
    chk("push addr", 16'h0800, memAddr);
    chk("push data", 16'h1234, memWdata);
    chk("push sp", 16'h0802, stackPtr);
    op(scea_pkg::SCEA_CALL_PUSH, 4'h0, 16'sh0000, 16'h0000, 1'b1);
    chk("call data", 16'h007a, memWdata);
    op(scea_pkg::SCEA_EXC_PUSH, 4'h0, 16'sh0000, 16'h0000, 1'b1);
    chk("exc data", 16'ha57a, memWdata);
    op(scea_pkg::SCEA_POP, 4'h0, 16'sh0000, 16'h0000, 1'b0);
    chk("pop addr", 16'h0804, memAddr);
    chk("pop re", 16'h0001, 16'(memRe));
  endtask

  task automatic t_limit();
    op(scea_pkg::SCEA_LIMIT_WRITE, 4'h0, 16'sh0000, 16'h0803, 1'b0);
    chk("limit", 16'h0802, stackLimit);
    // A push, not a stack read, follows the limit write
    op(scea_pkg::SCEA_PUSH, 4'h0, 16'sh0000, 16'h0001, 1'b1);
    chk("trap below", 16'h0000, 16'(stackTrap));
    op(scea_pkg::SCEA_PUSH, 4'h0, 16'sh0000, 16'h0002, 1'b1);
    chk("trap equal", 16'h0000, 16'(stackTrap));
    op(scea_pkg::SCEA_PUSH, 4'h0, 16'sh0000, 16'h0003, 1'b1);
    chk("trap above", 16'h0001, 16'(stackTrap));
    chk("trap we", 16'h0000, 16'(memWe));
    @(posedge ref_clk);
    #1;
    chk("trap pulse", 16'h0000, 16'(stackTrap));
    do_reset();
    chk("limit kept", 16'h0802, stackLimit);
  endtask

  task automatic t_floor();
    op(scea_pkg::SCEA_POP, 4'h0, 16'sh0000, 16'h0000, 1'b0);
    chk("floor addr", 16'h07fe, memAddr);
    chk("floor trap", 16'h0001, 16'(stackTrap));
    op(scea_pkg::SCEA_REG_WRITE, scea_pkg::SP_INDEX, 16'sh0000, 16'h07f0, 1'b0);
    op(scea_pkg::SCEA_IND, scea_pkg::SP_INDEX, 16'sh0000, 16'h0000, 1'b0);
    chk("sp ind addr", 16'h07f0, memAddr);
    chk("sp ind trap", 16'h0001, 16'(stackTrap));
  endtask

  task automatic t_modes();
    op(scea_pkg::SCEA_REG_WRITE, 4'h3, 16'sh0000, 16'h1000, 1'b0);
    op(scea_pkg::SCEA_REG_WRITE, 4'h4, 16'sh0000, 16'h0010, 1'b0);
    op(scea_pkg::SCEA_IND_POST, 4'h3, 16'sh0002, 16'h0000, 1'b0);
    chk("post addr", 16'h1000, memAddr);
    op(scea_pkg::SCEA_IND, 4'h3, 16'sh0000, 16'h0000, 1'b0);
    chk("ind addr", 16'h1002, memAddr);
    op(scea_pkg::SCEA_IND_PRE, 4'h3, -16'sh0004, 16'h0000, 1'b0);
    chk("pre addr", 16'h0ffe, memAddr);
    op(scea_pkg::SCEA_IND_REG_OFS, 4'h3, 16'sh0000, 16'h0000, 1'b0);
    chk("reg ofs", 16'h100e, memAddr);
    chk("operand1", 16'h0010, operand1);
    op(scea_pkg::SCEA_LITERAL, 4'h0, 16'sh0000, 16'h0000, 1'b0);
    chk("lit5", 16'h000c, operand2);
    @(posedge ref_clk);
    literalWide <= 1'b1;
    op(scea_pkg::SCEA_LITERAL, 4'h0, 16'sh0000, 16'h0000, 1'b0);
    chk("lit10", 16'h03ec, operand2);
    op(scea_pkg::SCEA_IND_LIT_OFS, 4'h3, 16'sh0000, 16'h0000, 1'b0);
    chk("lit ofs", 16'h13ea, memAddr);
    op(scea_pkg::SCEA_FILE_DIRECT, 4'h0, 16'sh0000, 16'h5555, 1'b1);
    chk("file addr", 16'h1abc, memAddr);
    @(posedge ref_clk);
    opMove <= 1'b1;
    op(scea_pkg::SCEA_FILE_DIRECT, 4'h0, 16'sh0000, 16'h5555, 1'b1);
    chk("move addr", 16'hfedc, memAddr);
    @(posedge ref_clk);
    opMove <= 1'b0;
    opToWreg <= 1'b1;
    op(scea_pkg::SCEA_FILE_DIRECT, 4'h0, 16'sh0000, 16'h5555, 1'b1);
    chk("default_working_reg we", 16'h0000, 16'(memWe));
    op(scea_pkg::SCEA_REG_DIRECT, scea_pkg::DEFAULT_WORKING_REG_INDEX, 16'sh0000, 16'h0000, 1'b0);
    chk("default_working_reg value", 16'h5555, operand2);
    @(posedge ref_clk);
    opToWreg <= 1'b0;
  endtask

  task automatic t_secure();
    op(scea_pkg::SCEA_REG_WRITE, 4'h5, 16'sh0000, 16'h0880, 1'b0);
    op(scea_pkg::SCEA_REG_WRITE, 4'h6, 16'sh0000, 16'h0980, 1'b0);
    @(posedge ref_clk);
    bootRamEn <= 1'b1;
    segRamEn <= 1'b1;
    seen = wrCount;
    op(scea_pkg::SCEA_IND, 4'h5, 16'sh0000, 16'h1111, 1'b1);
    chk("boot other we", 16'h0000, 16'(memWe));
    chk("boot other viol", 16'h0001, 16'(accessViolation));
    op(scea_pkg::SCEA_IND, 4'h6, 16'sh0000, 16'h2222, 1'b1);
    chk("seg other we", 16'h0000, 16'(memWe));
    @(posedge ref_clk);
    #1;
    chk("store kept", seen, wrCount);
    codeSeg <= scea_pkg::SCEA_CODE_BOOT;
    op(scea_pkg::SCEA_IND, 4'h5, 16'sh0000, 16'h3333, 1'b1);
    chk("boot boot we", 16'h0001, 16'(memWe));
    op(scea_pkg::SCEA_IND, 4'h6, 16'sh0000, 16'h4444, 1'b1);
    chk("seg boot viol", 16'h0001, 16'(accessViolation));
    chk("boot data", 16'h3333, lastData);
    chk("boot addr", 16'h0880, lastAddr);
    @(posedge ref_clk);
    codeSeg <= scea_pkg::SCEA_CODE_SECURE;
    op(scea_pkg::SCEA_IND, 4'h6, 16'sh0000, 16'h5555, 1'b1);
    chk("seg secure we", 16'h0001, 16'(memWe));
    op(scea_pkg::SCEA_IND, 4'h5, 16'sh0000, 16'h0000, 1'b0);
    chk("boot secure re", 16'h0000, 16'(memRe));
    chk("boot secure viol", 16'h0001, 16'(accessViolation));
  endtask

  initial
  begin
    do_reset();
    t_stack();
    do_reset();
    t_limit();
    t_floor();
    t_modes();
    t_secure();
    end_sim();
  end
endmodule // stack_check_and_ea_generation_bench
`default_nettype wire
